// file: verilog/gpsr_pkg.sv
package gpsr_pkg;

	// ---------------------------------------------------------------
	// Port geometry
	// ---------------------------------------------------------------
	localparam int PIN_COUNT    = 6;
	localparam int OUT_ONLY_PIN = 4;
	localparam int IN_ONLY_PIN  = 5;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_PORT_DATA   = 8'h00;
	localparam logic [7:0] OFS_PORT_DIR    = 8'h04;
	localparam logic [7:0] OFS_PULLUP      = 8'h08;
	localparam logic [7:0] OFS_SLEW        = 8'h0c;
	localparam logic [7:0] OFS_DRIVE       = 8'h10;
	localparam logic [7:0] OFS_PIN_FUNC    = 8'h14;
	localparam logic [7:0] OFS_POWER_CTRL2 = 8'h18;
	localparam logic [7:0] OFS_POWER_STATE = 8'h1c;

	// ---------------------------------------------------------------
	// Field positions of power_mgmt_status_control_2 and the pin function register
	// ---------------------------------------------------------------
	localparam int WARN_FLAG_BIT    = 7;
	localparam int WARN_ACK_BIT     = 6;
	localparam int DETECT_TRIP_BIT  = 5;
	localparam int WARN_TRIP_BIT    = 4;
	localparam int PPD_FLAG_BIT     = 3;
	localparam int PPD_ACK_BIT      = 2;
	localparam int STOP_DEPTH_BIT   = 0;
	localparam int BKGD_FUNC_BIT    = 0;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [5:0] PORT_REG_RESET  = 6'h00;
	localparam logic       BKGD_FUNC_RESET = 1'b1;
	localparam logic [7:0] POWER2_RESET    = 8'h00;

	// ---------------------------------------------------------------
	// Power states
	// ---------------------------------------------------------------
	typedef enum logic [4:0]
	{
		ST_RUN   = 5'b00001,
		ST_LIGHT = 5'b00010,
		ST_PPD   = 5'b00100,
		ST_DEEP  = 5'b01000,
		ST_HOLD  = 5'b10000
	} gpsr_state_type;

	typedef struct packed
	{
		gpsr_state_type state;
		logic [5:0]     portData;
		logic [5:0]     portDir;
		logic [5:0]     pullReg;
		logic [5:0]     slewReg;
		logic [5:0]     driveReg;
		logic           bkgdFunc;
		logic           warnFlag;
		logic           detectTrip;
		logic           warnTrip;
		logic           ppdFlag;
		logic           stopDepth;
		logic           stopDepthLocked;
		logic [5:0]     holdOut;
		logic [5:0]     holdOe;
		logic [5:0]     holdPull;
		logic [5:0]     holdSlew;
		logic [5:0]     holdDrive;
		logic           ack;
		logic [7:0]     rdData;
	} gpsr_regs_type;

endpackage

// file: verilog/gpsr_port.sv
`timescale 1ns/1ps

// Overview of operation
// - Enabled shared peripheral takes the pin
// - Reset: debug function on output-only pin, others inputs, pullups off
// - Direction bit drives buffer, selects read source
// - Input buffer on unless analog or output-only
// - Shared digital drives pin; direction picks read
// - Analog kills both buffers; input reads zero
// - Analog wins over digital alternate function
// - Deepest stop: all port state to reset
// - Partial power-down latches pins; registers lost
// - Light stop keeps every pin and function
// - Warning flag sets on low supply
// - Warning ack clears flag if warning gone
// - Detect trip select, power-on reset only
// - Warning trip select, power-on reset only
// - Power-down flag set on partial power-down exit
// - Power-down ack write clears the flag
// - Stop depth select accepts first write only
// - Pullup, slew, drive independent of data
// - Pullup only on plain GPIO inputs
module gpsr_port
(
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        porReset,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Stop mode sequencing
	input  wire logic        stopEnter,
	input  wire logic        stopDeep,
	input  wire logic        stopExit,
	output logic             pinsHeld,
	// Supply monitor
	input  wire logic        lowVoltWarnPresent,
	output logic             detectTripSelect,
	output logic             warnTripSelect,
	output logic             stopDepthSelect,
	// Shared peripheral functions
	input  wire logic [5:0]  periphDigEn,
	input  wire logic [5:0]  periphDigOut,
	input  wire logic [5:0]  periphDigOe,
	input  wire logic [5:0]  periphAnaEn,
	output logic      [5:0]  periphDigIn,
	// Background debug on the output-only pin
	input  wire logic        bkgdOut,
	input  wire logic        bkgdOe,
	// Port pins
	input  wire logic [5:0]  pinIn,
	output logic      [5:0]  pinOut,
	output logic      [5:0]  pinOe,
	output logic      [5:0]  pinPullup,
	output logic      [5:0]  pinSlew,
	output logic      [5:0]  pinDrive,
	output logic      [5:0]  pinInBufEn
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic regHit
	(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		regHit = (addr[7:2] == ofs[7:2]);
	endfunction

	localparam gpsr_pkg::gpsr_regs_type REGS_RESET = '{
		state:    gpsr_pkg::ST_RUN,
		portData: gpsr_pkg::PORT_REG_RESET,
		portDir:  gpsr_pkg::PORT_REG_RESET,
		pullReg:  gpsr_pkg::PORT_REG_RESET,
		slewReg:  gpsr_pkg::PORT_REG_RESET,
		driveReg: gpsr_pkg::PORT_REG_RESET,
		bkgdFunc: gpsr_pkg::BKGD_FUNC_RESET,
		default:  '0
	};

	gpsr_pkg::gpsr_regs_type cur;
	gpsr_pkg::gpsr_regs_type next_cur;

	logic [5:0] liveOut;
	logic [5:0] liveOe;
	logic [5:0] livePull;
	logic [5:0] readBits;
	logic [5:0] digEn;
	logic [5:0] digOut;
	logic [5:0] digOe;
	logic       held;
	logic       busWrite;
	logic [7:0] power2Read;

	// ---------------------------------------------------------------
	// Per-pin steering
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < gpsr_pkg::PIN_COUNT; i++)
		begin : gPin
			logic analog;
			logic inBuf;
			assign analog = periphAnaEn[i];
			if (i == gpsr_pkg::OUT_ONLY_PIN)
			begin : gOutOnly
				// Debug function owns the pin until software frees it
				assign digEn[i]  = periphDigEn[i] | cur.bkgdFunc;
				assign digOut[i] = cur.bkgdFunc ? bkgdOut : periphDigOut[i];
				assign digOe[i]  = cur.bkgdFunc ? bkgdOe : periphDigOe[i];
				assign inBuf     = 1'b0;
				// Output-only: direction has no effect, driver on unless analog; a shared function that owns the pin sets it by its own enable
				assign liveOe[i] = analog ? 1'b0 :
					(digEn[i] ? digOe[i] : 1'b1);
				assign readBits[i] = cur.portData[i];
			end
			else if (i == gpsr_pkg::IN_ONLY_PIN)
			begin : gInOnly
				assign digEn[i]    = periphDigEn[i];
				assign digOut[i]   = periphDigOut[i];
				assign digOe[i]    = 1'b0;
				assign inBuf       = ~analog;
				assign liveOe[i]   = 1'b0;
				assign readBits[i] = pinIn[i] & inBuf;
			end
			else
			begin : gBidir
				assign digEn[i]  = periphDigEn[i];
				assign digOut[i] = periphDigOut[i];
				assign digOe[i]  = periphDigOe[i];
				assign inBuf     = ~analog;
				assign liveOe[i] = analog ? 1'b0 :
					(digEn[i] ? digOe[i] : cur.portDir[i]);
				// Direction keeps choosing the read source under sharing
				assign readBits[i] = cur.portDir[i] ? cur.portData[i] :
					(pinIn[i] & inBuf);
			end
			assign liveOut[i] = (digEn[i] & ~analog) ?
				digOut[i] : cur.portData[i];
			// Pullup only for a plain GPIO input
			assign livePull[i] = cur.pullReg[i] & ~liveOe[i] & ~digEn[i]
				& ~analog & (i != gpsr_pkg::OUT_ONLY_PIN);
			assign pinInBufEn[i]  = inBuf;
			assign periphDigIn[i] = pinIn[i] & inBuf;
		end
	endgenerate

	// ---------------------------------------------------------------
	// Pin outputs, retention latches override
	// ---------------------------------------------------------------
	assign held = (cur.state == gpsr_pkg::ST_PPD)
		| (cur.state == gpsr_pkg::ST_HOLD);
	assign pinOut    = held ? cur.holdOut   : liveOut;
	assign pinOe     = held ? cur.holdOe    : liveOe;
	assign pinPullup = held ? cur.holdPull  : livePull;
	// Slew and drive bypass data and direction entirely
	assign pinSlew   = held ? cur.holdSlew  : cur.slewReg;
	assign pinDrive  = held ? cur.holdDrive : cur.driveReg;
	assign pinsHeld  = held;

	assign detectTripSelect = cur.detectTrip;
	assign warnTripSelect   = cur.warnTrip;
	assign stopDepthSelect  = cur.stopDepth;
	assign ack_o            = cur.ack;
	assign dat_o            = {24'h000000, cur.rdData};

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	always_comb
	begin
		power2Read = gpsr_pkg::POWER2_RESET;
		power2Read[gpsr_pkg::WARN_FLAG_BIT]   = cur.warnFlag;
		power2Read[gpsr_pkg::DETECT_TRIP_BIT] = cur.detectTrip;
		power2Read[gpsr_pkg::WARN_TRIP_BIT]   = cur.warnTrip;
		power2Read[gpsr_pkg::PPD_FLAG_BIT]    = cur.ppdFlag;
		power2Read[gpsr_pkg::STOP_DEPTH_BIT]  = cur.stopDepth;
	end

	// Write takes effect on the edge where the master sees ack
	assign busWrite = cyc_i & stb_i & we_i & cur.ack & sel_i[0];

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_cur     = cur;
		next_cur.ack = cyc_i & stb_i & ~cur.ack;
		next_cur.rdData = 8'h00;
		if (regHit(adr_i, gpsr_pkg::OFS_PORT_DATA))
			next_cur.rdData = {2'b00, readBits};
		else if (regHit(adr_i, gpsr_pkg::OFS_PORT_DIR))
			next_cur.rdData = {3'b000, cur.portDir[4:0]};
		else if (regHit(adr_i, gpsr_pkg::OFS_PULLUP))
			next_cur.rdData = {2'b00, cur.pullReg};
		else if (regHit(adr_i, gpsr_pkg::OFS_SLEW))
			next_cur.rdData = {2'b00, cur.slewReg};
		else if (regHit(adr_i, gpsr_pkg::OFS_DRIVE))
			next_cur.rdData = {2'b00, cur.driveReg};
		else if (regHit(adr_i, gpsr_pkg::OFS_PIN_FUNC))
			next_cur.rdData = {7'h00, cur.bkgdFunc};
		else if (regHit(adr_i, gpsr_pkg::OFS_POWER_CTRL2))
			next_cur.rdData = power2Read;
		else if (regHit(adr_i, gpsr_pkg::OFS_POWER_STATE))
			next_cur.rdData = {3'b000, cur.state};

		if (busWrite)
		begin
			if (regHit(adr_i, gpsr_pkg::OFS_PORT_DATA))
				next_cur.portData = dat_i[5:0];
			if (regHit(adr_i, gpsr_pkg::OFS_PORT_DIR))
				next_cur.portDir = {1'b0, dat_i[4:0]};
			if (regHit(adr_i, gpsr_pkg::OFS_PULLUP))
				next_cur.pullReg = dat_i[5:0];
			if (regHit(adr_i, gpsr_pkg::OFS_SLEW))
				next_cur.slewReg = dat_i[5:0];
			if (regHit(adr_i, gpsr_pkg::OFS_DRIVE))
				next_cur.driveReg = dat_i[5:0];
			if (regHit(adr_i, gpsr_pkg::OFS_PIN_FUNC))
				next_cur.bkgdFunc = dat_i[gpsr_pkg::BKGD_FUNC_BIT];
			if (regHit(adr_i, gpsr_pkg::OFS_POWER_CTRL2))
			begin
				// A warning still present keeps the flag up
				if (dat_i[gpsr_pkg::WARN_ACK_BIT] & ~lowVoltWarnPresent)
					next_cur.warnFlag = 1'b0;
				next_cur.detectTrip =
					dat_i[gpsr_pkg::DETECT_TRIP_BIT];
				next_cur.warnTrip = dat_i[gpsr_pkg::WARN_TRIP_BIT];
				if (dat_i[gpsr_pkg::PPD_ACK_BIT])
				begin
					next_cur.ppdFlag = 1'b0;
					if (cur.state == gpsr_pkg::ST_HOLD)
						next_cur.state = gpsr_pkg::ST_RUN;
				end
				if (~cur.stopDepthLocked)
				begin
					next_cur.stopDepth =
						dat_i[gpsr_pkg::STOP_DEPTH_BIT];
					next_cur.stopDepthLocked = 1'b1;
				end
			end
		end

		// Level set wins over an acknowledge in the same cycle
		if (lowVoltWarnPresent)
			next_cur.warnFlag = 1'b1;

		case (cur.state)
			gpsr_pkg::ST_RUN:
			begin
				if (stopEnter)
				begin
					if (stopDeep)
						next_cur.state = gpsr_pkg::ST_DEEP;
					else if (cur.stopDepth)
					begin
						next_cur.state     = gpsr_pkg::ST_PPD;
						next_cur.holdOut   = liveOut;
						next_cur.holdOe    = liveOe;
						next_cur.holdPull  = livePull;
						next_cur.holdSlew  = cur.slewReg;
						next_cur.holdDrive = cur.driveReg;
					end
					else
						next_cur.state = gpsr_pkg::ST_LIGHT;
				end
			end
			gpsr_pkg::ST_LIGHT:
			begin
				// Nothing is touched: light stop keeps logic powered
				if (stopExit)
					next_cur.state = gpsr_pkg::ST_RUN;
			end
			gpsr_pkg::ST_PPD:
			begin
				// Register contents are not retained, only the latches
				next_cur.portData = gpsr_pkg::PORT_REG_RESET;
				next_cur.portDir  = gpsr_pkg::PORT_REG_RESET;
				next_cur.pullReg  = gpsr_pkg::PORT_REG_RESET;
				next_cur.slewReg  = gpsr_pkg::PORT_REG_RESET;
				next_cur.driveReg = gpsr_pkg::PORT_REG_RESET;
				next_cur.bkgdFunc = gpsr_pkg::BKGD_FUNC_RESET;
				if (stopExit)
				begin
					next_cur.state   = gpsr_pkg::ST_HOLD;
					next_cur.ppdFlag = 1'b1;
				end
			end
			gpsr_pkg::ST_DEEP:
			begin
				// Port registers return to reset defaults while powered off
				next_cur.portData = gpsr_pkg::PORT_REG_RESET;
				next_cur.portDir  = gpsr_pkg::PORT_REG_RESET;
				next_cur.pullReg  = gpsr_pkg::PORT_REG_RESET;
				next_cur.slewReg  = gpsr_pkg::PORT_REG_RESET;
				next_cur.driveReg = gpsr_pkg::PORT_REG_RESET;
				next_cur.bkgdFunc = gpsr_pkg::BKGD_FUNC_RESET;
				next_cur.ppdFlag  = 1'b0;
				if (stopExit)
					next_cur.state = gpsr_pkg::ST_RUN;
			end
			gpsr_pkg::ST_HOLD:
			begin
				// Left only by the acknowledge write above
				next_cur.state = next_cur.state;
			end
			default:
			begin
				next_cur.state = gpsr_pkg::ST_RUN;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (porReset)
			cur <= REGS_RESET;
		else if (rst)
		begin
			// Trip selects survive every reset but power-on
			cur            <= REGS_RESET;
			cur.detectTrip <= cur.detectTrip;
			cur.warnTrip   <= cur.warnTrip;
		end
		else
			cur <= next_cur;
	end

endmodule

// file: sim/gpsr_checker.sv
`timescale 1ns/1ps
module gpsr_checker
(
	// Clock and resets
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       porReset,
	// Bus and power
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       we_i,
	input wire logic [7:0] adr_i,
	input wire logic       ack_o,
	input wire logic       stopEnter,
	input wire logic       pinsHeld,
	input wire logic       stopDepthSelect,
	input wire logic       detectTripSelect,
	input wire logic       warnTripSelect,
	// Pins
	input wire logic [5:0] periphDigEn,
	input wire logic [5:0] periphDigOut,
	input wire logic [5:0] periphDigOe,
	input wire logic [5:0] periphAnaEn,
	input wire logic [5:0] pinOut,
	input wire logic [5:0] pinOe,
	input wire logic [5:0] pinPullup,
	input wire logic [5:0] pinInBufEn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || porReset);
	logic locked;
	// Stop entry drops the lock, so the check waits for the next power register write
	always_ff @(posedge clk_sys)
	begin
		if (rst || porReset || stopEnter)
			locked <= 1'b0;
		else if (ack_o && we_i && adr_i == 8'h18)
			locked <= 1'b1;
	end
	a_ack_late: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus answer late");
	a_inbuf_on: assert property (
		!pinsHeld |-> pinInBufEn == (~periphAnaEn & 6'h2f))
		else $error("input buffer enable wrong");
	a_analog_off: assert property (
		!pinsHeld |-> (pinOe & periphAnaEn) == 6'h00)
		else $error("analog pin driven");
	a_digital_drive: assert property (
		!pinsHeld |-> (((pinOut ^ periphDigOut) | (pinOe ^ periphDigOe))
		& periphDigEn & ~periphAnaEn & 6'h0f) == 6'h00)
		else $error("shared function not on pin");
	a_pull_off: assert property (
		!pinsHeld |-> (pinPullup & (pinOe | periphDigEn | periphAnaEn)) == 0)
		else $error("pullup on driven pin");
	a_held_start: assert property ($rose(pinsHeld) |-> $past(stopEnter))
		else $error("hold without stop");
	a_held_stable: assert property (
		pinsHeld && $past(pinsHeld) |-> $stable(pinOut) && $stable(pinOe))
		else $error("held pins moved");
	a_depth_lock: assert property (
		locked && !stopEnter |=> $stable(stopDepthSelect))
		else $error("stop depth rewritten");
	a_trip_keep: assert property (
		@(posedge clk_sys) disable iff (porReset)
		rst |=> $stable(detectTripSelect) && $stable(warnTripSelect))
		else $error("trip select lost on reset");
	c_write: cover property (ack_o && we_i);
	c_hold: cover property ($rose(pinsHeld));
	c_shared: cover property ((periphAnaEn & periphDigEn) != 6'h00);
endmodule

// file: sim/gpsr_board.sv
`timescale 1ns/1ps
module gpsr_board
(
	// Clock and pad controls
	input  wire logic       clk_sys,
	input  wire logic [5:0] pinOut,
	input  wire logic [5:0] pinOe,
	input  wire logic [5:0] pinPullup,
	// Board drivers
	input  wire logic [5:0] extEn,
	input  wire logic [5:0] extVal,
	output logic      [5:0] pinIn
);
	logic [5:0] lastLevel;
	// Undriven pins without pullup wander, so a stale level never passes
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
		| (~pinOe & ~extEn & (pinPullup | ~lastLevel));
	always_ff @(posedge clk_sys)
		lastLevel <= pinIn;
endmodule

// file: sim/gpsr_port_tb.sv
`timescale 1ns/1ps
module gpsr_port_tb;
	logic clk_sys, rst, porReset, cyc, stb, we, ackO, lowVolt;
	logic stopEnter, stopDeep, stopExit, pinsHeld, detSel, warnSel, depthSel;
	logic [7:0] adr, rdata;
	logic [31:0] datI, datO;
	logic [5:0] digEn, digOut, digOe, anaEn, pinIn, pinOut, pinOe, pinPull;
	logic [5:0] pinSlew, pinDrive, inBuf, extEn, extVal;
	int miscompares, numChecks;
	gpsr_port i_gpsr_port (.clk_sys, .rst, .porReset, .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(datI),
		.dat_o(datO), .ack_o(ackO), .stopEnter, .stopDeep, .stopExit,
		.pinsHeld, .lowVoltWarnPresent(lowVolt), .detectTripSelect(detSel),
		.warnTripSelect(warnSel), .stopDepthSelect(depthSel),
		.periphDigEn(digEn), .periphDigOut(digOut), .periphDigOe(digOe),
		.periphAnaEn(anaEn), .periphDigIn(), .bkgdOut(1'b0), .bkgdOe(1'b0),
		.pinIn, .pinOut, .pinOe, .pinPullup(pinPull), .pinSlew, .pinDrive,
		.pinInBufEn(inBuf));
	gpsr_board i_gpsr_board (.clk_sys, .pinOut, .pinOe, .pinPullup(pinPull),
		.extEn, .extVal, .pinIn);
	// ---------------------------------------------------------------
	// Bus and check helpers
	// ---------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		numChecks++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= {24'h000000, d};
		n = 0;
		@(posedge clk_sys);
		while (ackO !== 1'b1 && n < 50)
		begin
			@(posedge clk_sys);
			n++;
		end
		rdata = datO[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			end_sim;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(rdata, e);
	endtask
	task rstPulse;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task enter(input logic d);
		@(posedge clk_sys);
		stopEnter <= 1'b1;
		stopDeep <= d;
		@(posedge clk_sys);
		stopEnter <= 1'b0;
	endtask
	task leave;
		@(posedge clk_sys);
		stopExit <= 1'b1;
		@(posedge clk_sys);
		stopExit <= 1'b0;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_reset;
		rd(8'h04, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h14, 8'h01);
		rd(8'h18, 8'h00);
		rd(8'h1c, 8'h01);
		rd(8'h20, 8'h00);
	endtask
	task t_dir;
		wr(8'h00, 8'h1a);
		wr(8'h04, 8'h2f);
		rd(8'h04, 8'h0f);
		chk(8'(pinOut & 6'h0f), 8'h0a);
		extVal <= 6'h25;
		rd(8'h00, 8'h3a);
		wr(8'h04, 8'h00);
		rd(8'h00, 8'h35);
	endtask
	task t_mux;
		digEn <= 6'h03;
		digOut <= 6'h01;
		digOe <= 6'h03;
		anaEn <= 6'h0a;
		@(negedge clk_sys);
		chk(8'(pinOe & 6'h0f), 8'h01);
		chk(8'(inBuf), 8'h25);
		rd(8'h00, 8'h35);
		wr(8'h04, 8'h01);
		rd(8'h00, 8'h34);
		digEn <= 6'h00;
		anaEn <= 6'h00;
		wr(8'h08, 8'h2f);
		wr(8'h0c, 8'h05);
		wr(8'h10, 8'h0b);
		chk(8'(pinPull), 8'h2e);
		chk(8'(pinSlew), 8'h05);
		wr(8'h04, 8'h00);
		@(negedge clk_sys);
		chk(8'(pinPull), 8'h2f);
		chk(8'(pinDrive), 8'h0b);
		@(posedge clk_sys);
		extEn <= 6'h1f;
		extVal <= 6'h05;
		rd(8'h00, 8'h35);
	endtask
	task t_warn;
		lowVolt <= 1'b1;
		wr(8'h18, 8'h70);
		rd(8'h18, 8'hb0);
		lowVolt <= 1'b0;
		wr(8'h18, 8'h70);
		rd(8'h18, 8'h30);
		lowVolt <= 1'b1;
		rstPulse;
		rd(8'h18, 8'hb0);
		lowVolt <= 1'b0;
		wr(8'h18, 8'h70);
		wr(8'h00, 8'h05);
		wr(8'h04, 8'h0f);
		enter(1'b0);
		rd(8'h1c, 8'h02);
		leave;
		rd(8'h04, 8'h0f);
		chk(8'(pinOut & 6'h0f), 8'h05);
	endtask
	task t_ppd;
		rstPulse;
		wr(8'h18, 8'h01);
		wr(8'h18, 8'h00);
		rd(8'h18, 8'h01);
		wr(8'h00, 8'h09);
		wr(8'h04, 8'h0f);
		enter(1'b0);
		rd(8'h1c, 8'h04);
		chk(8'(pinOe & 6'h0f), 8'h0f);
		leave;
		wb(1'b0, 8'h18, 8'h00);
		chk(rdata & 8'h08, 8'h08);
		chk(8'(pinOut & 6'h0f), 8'h09);
		wr(8'h18, 8'h04);
		rd(8'h18, 8'h01);
		chk(8'(pinOe & 6'h0f), 8'h00);
		wr(8'h04, 8'h0f);
		wr(8'h08, 8'h2f);
		enter(1'b1);
		rd(8'h1c, 8'h08);
		leave;
		rd(8'h04, 8'h00);
		rd(8'h14, 8'h01);
		chk(8'(pinPull), 8'h00);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		{rst, porReset, cyc, stb, we, lowVolt} = 6'h30;
		{stopEnter, stopDeep, stopExit} = 3'h0;
		{adr, datI, digEn, digOut, digOe, anaEn} = '0;
		{miscompares, numChecks} = '0;
		extEn = 6'h3f;
		extVal = 6'h00;
		lowVolt = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		porReset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_reset;
		t_dir;
		t_mux;
		t_warn;
		t_ppd;
		end_sim;
	end
endmodule
bind gpsr_port gpsr_checker i_gpsr_checker (.clk_sys, .rst, .porReset,
	.cyc_i, .stb_i, .we_i, .adr_i, .ack_o, .stopEnter, .pinsHeld,
	.stopDepthSelect, .detectTripSelect, .warnTripSelect, .periphDigEn,
	.periphDigOut, .periphDigOe, .periphAnaEn, .pinOut, .pinOe, .pinPullup,
	.pinInBufEn);
